// *** core/pwg_apb_front.sv ***
// APB request decode for the write guard registers
`timescale 1ns/1ps
module pwg_apb_front (
   // Request from the bus
   input wire pwg_pkg::pwg_req_t req,
   input wire logic pready_ff,
   // Decoded access
   output pwg_pkg::pwg_acc_t acc
);

   logic commit;

   always_comb begin
      commit = req.psel && req.penable && pready_ff && req.pwrite;
      acc.setup = req.psel && !req.penable;
      acc.hit = pwg_pkg::addr_is(req.paddr, pwg_pkg::OFF_CLEAR) || pwg_pkg::addr_is(req.paddr, pwg_pkg::OFF_SET);
      // Writes land only on the completing edge
      acc.wr_clr = commit && pwg_pkg::addr_is(req.paddr, pwg_pkg::OFF_CLEAR); // RULE7
      acc.wr_set = commit && pwg_pkg::addr_is(req.paddr, pwg_pkg::OFF_SET); // RULE4
      // Zero bits never touch the state
      acc.wmask = pwg_pkg::lane_mask(req.pwdata, req.pstrb) & pwg_pkg::GUARD_MASK; // RULE1
   end

endmodule

// *** core/pwg_guard_bank.sv ***
// Bank of write-protection state bits with set and clear strobes
`timescale 1ns/1ps
module pwg_guard_bank (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Update strobes
   input wire logic wr_clr,
   input wire logic wr_set,
   input wire logic [31:0] wmask,
   // State
   output logic [31:0] guard_ff
);

   genvar i;
   generate
      for (i = 0; i < 32; i++) begin : g_bit
         if (pwg_pkg::GUARD_MASK[i]) begin : g_live
            logic bit_ff;
            logic nxt_bit;
            // Set is tested last so it wins; the bus never raises both at once
            always_comb begin
               nxt_bit = bit_ff;
               if (wr_clr && wmask[i]) begin
                  nxt_bit = 1'b0; // RULE2
               end
               if (wr_set && wmask[i]) begin
                  nxt_bit = 1'b1; // RULE8
               end
            end
            always_ff @(posedge pclk or negedge presetn) begin
               if (!presetn) begin
                  bit_ff <= pwg_pkg::GUARD_RESET[i]; // RULE5
               end else begin
                  bit_ff <= nxt_bit;
               end
            end
            assign guard_ff[i] = bit_ff;
         end else begin : g_none
            assign guard_ff[i] = 1'b0;
         end
      end
   endgenerate

endmodule

// *** core/pwg_pkg.sv ***
// Shared constants, types and decode helpers for the peripheral write guard
package pwg_pkg;

   // Bus geometry
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;

   // Register byte offsets
   localparam logic [11:0] OFF_CLEAR = 12'h000;
   localparam logic [11:0] OFF_SET = 12'h004;

   // Value that both registers show after reset
   localparam logic [31:0] RESET_VALUE = 32'h0080_0000;

   // Guarded field positions
   localparam int unsigned EVENT_BIT = 1;
   localparam int unsigned SERIAL_LO = 2;
   localparam int unsigned SERIAL_HI = 7;
   localparam int unsigned TIMER_LO = 8;
   localparam int unsigned TIMER_HI = 15;
   localparam int unsigned ANALOG_IN_BIT = 16;
   localparam int unsigned COMPARATOR_BIT = 17;
   localparam int unsigned ANALOG_OUT_BIT = 18;
   localparam int unsigned TOUCH_BIT = 19;

   // Bits that hold protection state, and their value after reset
   localparam logic [31:0] GUARD_MASK = 32'h000f_fffe;
   localparam logic [31:0] GUARD_RESET = 32'h0000_0000;
   // Non-guard bits read back as the reset image
   localparam logic [31:0] FIXED_READ = RESET_VALUE & ~GUARD_MASK;

   // Cycles from the setup edge to pready
   localparam int unsigned ANSWER_CYCLES = 1;

   // One APB request as seen by the slave
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
      logic [3:0] pstrb;
   } pwg_req_t;

   // Decoded access for the guard bank and the answer logic
   typedef struct packed {
      logic setup;
      logic hit;
      logic wr_clr;
      logic wr_set;
      logic [31:0] wmask;
   } pwg_acc_t;

   // Word-aligned match against one register offset
   function automatic logic addr_is(input logic [11:0] addr, input logic [11:0] off);
      addr_is = (addr[11:2] == off[11:2]);
   endfunction

   // Write data with disabled byte lanes forced to zero
   function automatic logic [31:0] lane_mask(input logic [31:0] data, input logic [3:0] strb);
      logic [31:0] m;
      m = 32'h0000_0000;
      for (int i = 0; i < 4; i++) begin
         m[i*8 +: 8] = strb[i] ? data[i*8 +: 8] : 8'h00;
      end
      lane_mask = m;
   endfunction

endpackage

// *** core/pwg_top.sv ***
// Write guard for peripheral group two, reached over APB
//
// Summary of operation
// RULE1: Writing zero to any bit of either register leaves protection unchanged.
// RULE2: Writing one to a bit of the clear register removes that protection.
// RULE3: Reading a bit returns one when protection is on, zero when off.
// RULE4: Set register lives at offset 0x04, reset value 0x00800000, same layout.
// RULE5: Bits 19..16 guard analog blocks, bits 15..8 timers; all reset zero.
// RULE6: Bits 7..2 guard serial units five..zero, bit 1 events; reset zero.
// RULE7: Clear register lives at offset 0x00, reset value 0x00800000, same layout.
// RULE8: Writing one to a bit of the set register turns that protection on.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
module pwg_top (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB request
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   // APB answer
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // Protection state to the guarded peripherals
   output logic touch_guard_bit,
   output logic analog_out_guard_bit,
   output logic comparator_guard_bit,
   output logic analog_in_guard_bit,
   output logic [7:0] timer_guard_bits,
   output logic [5:0] serial_unit_guard_bits,
   output logic event_system_guard_bit
);

   ////////////////////////////////////////////////////////////////////////////
   // Request decode

   pwg_pkg::pwg_req_t req;
   pwg_pkg::pwg_acc_t acc;
   logic pready_ff;
   logic nxt_pready;
   logic [31:0] prdata_ff;
   logic [31:0] nxt_prdata;
   logic pslverr_ff;
   logic nxt_pslverr;
   logic [31:0] guard_ff;
   logic [31:0] readback;

   always_comb begin
      req.psel = psel;
      req.penable = penable;
      req.pwrite = pwrite;
      req.paddr = paddr;
      req.pwdata = pwdata;
      req.pstrb = pstrb;
   end

   pwg_apb_front u_front (
      .req(req),
      .pready_ff(pready_ff),
      .acc(acc)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Protection state

   pwg_guard_bank u_bank (
      .pclk(pclk),
      .presetn(presetn),
      .wr_clr(acc.wr_clr),
      .wr_set(acc.wr_set),
      .wmask(acc.wmask),
      .guard_ff(guard_ff)
   );

   // Both offsets show the same image
   always_comb begin
      readback = guard_ff | pwg_pkg::FIXED_READ; // RULE3
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB answer
   // Answer is computed in setup so pready/prdata come straight from flops;
   // this costs nothing since the access phase is the answer cycle.

   always_comb begin
      nxt_pready = acc.setup;
      nxt_prdata = 32'h0000_0000;
      nxt_pslverr = 1'b0;
      if (acc.setup && acc.hit && !req.pwrite) begin
         nxt_prdata = readback; // RULE3
      end
      if (acc.setup && !acc.hit) begin
         // Unmapped: refused, state untouched
         nxt_pslverr = 1'b1; // RULE4 RULE7
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff <= 1'b0;
         prdata_ff <= 32'h0000_0000;
         pslverr_ff <= 1'b0;
      end else begin
         pready_ff <= nxt_pready;
         prdata_ff <= nxt_prdata;
         pslverr_ff <= nxt_pslverr;
      end
   end

   always_comb begin
      pready = pready_ff;
      prdata = prdata_ff;
      pslverr = pslverr_ff;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Field outputs

   always_comb begin
      touch_guard_bit = guard_ff[pwg_pkg::TOUCH_BIT]; // RULE5
      analog_out_guard_bit = guard_ff[pwg_pkg::ANALOG_OUT_BIT];
      comparator_guard_bit = guard_ff[pwg_pkg::COMPARATOR_BIT];
      analog_in_guard_bit = guard_ff[pwg_pkg::ANALOG_IN_BIT];
      timer_guard_bits = guard_ff[pwg_pkg::TIMER_HI:pwg_pkg::TIMER_LO]; // RULE5
      serial_unit_guard_bits = guard_ff[pwg_pkg::SERIAL_HI:pwg_pkg::SERIAL_LO]; // RULE6
      event_system_guard_bit = guard_ff[pwg_pkg::EVENT_BIT]; // RULE6
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   logic seen_ff;
   logic nxt_seen;

   always_comb begin
      nxt_seen = 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seen_ff <= 1'b0;
      end else begin
         seen_ff <= nxt_seen;
      end
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   AST_ZERO_KEEPS: assert property ( // RULE1
      (acc.wr_clr || acc.wr_set) |=> (((guard_ff ^ $past(guard_ff)) & ~$past(acc.wmask)) == 32'h0000_0000)
   ) else $error("Bit written as zero changed state");

   AST_CLEAR_REMOVES: assert property ( // RULE2
      acc.wr_clr |=> ((guard_ff & $past(acc.wmask)) == 32'h0000_0000)
   ) else $error("Clear write left protection on");

   AST_SET_ENABLES: assert property ( // RULE8
      acc.wr_set |=> ((guard_ff & $past(acc.wmask)) == $past(acc.wmask))
   ) else $error("Set write left protection off");

   AST_READ_SHOWS: assert property ( // RULE3
      (psel && !penable && !pwrite && acc.hit) |=> (pready && !pslverr && prdata == $past(readback))
   ) else $error("Read data does not match protection state");

   AST_SET_OFFSET: assert property ( // RULE4
      (acc.setup && paddr == pwg_pkg::OFF_SET) |=> (pready && !pslverr)
   ) else $error("Set register offset refused");

   AST_CLEAR_OFFSET: assert property ( // RULE7
      (acc.setup && paddr == pwg_pkg::OFF_CLEAR) |=> (pready && !pslverr)
   ) else $error("Clear register offset refused");

   AST_RESET_IMAGE: assert property ( // RULE4
      !seen_ff |-> (readback == pwg_pkg::RESET_VALUE)
   ) else $error("Register image wrong after reset");

   AST_TIMER_QUIET: assert property ( // RULE5
      !(acc.wr_clr || acc.wr_set) |=> $stable(timer_guard_bits) && $stable(guard_ff[19:16])
   ) else $error("Timer or analog guard moved without a write");

   AST_SERIAL_QUIET: assert property ( // RULE6
      !(acc.wr_clr || acc.wr_set) |=> $stable(serial_unit_guard_bits) && $stable(event_system_guard_bit)
   ) else $error("Serial or event guard moved without a write");

   AST_RESET_ZERO: assert property ( // RULE6
      !seen_ff |-> (timer_guard_bits == 8'h00 && serial_unit_guard_bits == 6'h00 && !event_system_guard_bit)
   ) else $error("Guard bits not zero after reset");

   AST_UNMAPPED: assert property (
      (acc.setup && !acc.hit) |=> (pready && pslverr) ##1 !pready
   ) else $error("Unmapped access not refused in one cycle");

   AST_RESERVED_FIXED: assert property ( // RULE4 RULE7
      (acc.setup && acc.hit && !pwrite) |=> ((prdata & ~pwg_pkg::GUARD_MASK) == pwg_pkg::FIXED_READ)
   ) else $error("Non-guard bits read wrong");

   ////////////////////////////////////////////////////////////////////////////
   // Answer timing checks

   AST_READY_AFTER_SETUP: assert property (
      acc.setup |=> pready
   ) else $error("No answer in the cycle after setup");

   AST_READY_PULSE: assert property (
      pready |=> !pready
   ) else $error("Ready held longer than one cycle");

   AST_READY_CAUSE: assert property (
      pready |-> $past(acc.setup)
   ) else $error("Ready without a setup cycle before it");

   AST_IDLE_QUIET_BUS: assert property (
      !pready |-> (prdata == 32'h0000_0000 && !pslverr)
   ) else $error("Answer signals busy outside an answer cycle");

   AST_WRITE_NO_DATA: assert property (
      (acc.setup && pwrite) |=> (prdata == 32'h0000_0000)
   ) else $error("Write answered with read data");

   AST_MAPPED_NO_ERR: assert property ( // RULE4 RULE7
      (acc.setup && acc.hit) |=> !pslverr
   ) else $error("Mapped register refused");

   AST_PRDATA_UNMAPPED: assert property (
      (acc.setup && !acc.hit) |=> (prdata == 32'h0000_0000)
   ) else $error("Unmapped read returned data");

   AST_ERR_ONLY_UNMAPPED: assert property (
      pslverr |-> $past(acc.setup && !acc.hit)
   ) else $error("Error answer for a mapped access");

   // Reads must never disturb protection
   AST_READ_NO_CHANGE: assert property (
      (psel && penable && !pwrite) |=> $stable(guard_ff)
   ) else $error("Read access changed protection state");

   ////////////////////////////////////////////////////////////////////////////
   // Field output checks

   logic [3:0] analog_view;
   logic [3:0] analog_wmask;
   logic [7:0] timer_wmask;
   logic [5:0] serial_wmask;

   always_comb begin
      analog_view = {touch_guard_bit, analog_out_guard_bit, comparator_guard_bit, analog_in_guard_bit};
      analog_wmask = acc.wmask[pwg_pkg::TOUCH_BIT:pwg_pkg::ANALOG_IN_BIT];
      timer_wmask = acc.wmask[pwg_pkg::TIMER_HI:pwg_pkg::TIMER_LO];
      serial_wmask = acc.wmask[pwg_pkg::SERIAL_HI:pwg_pkg::SERIAL_LO];
   end

   AST_ANALOG_SET: assert property ( // RULE5
      acc.wr_set |=> ((analog_view & $past(analog_wmask)) == $past(analog_wmask))
   ) else $error("Analog guard not set by a set write");

   AST_ANALOG_CLEAR: assert property ( // RULE5
      acc.wr_clr |=> ((analog_view & $past(analog_wmask)) == 4'h0)
   ) else $error("Analog guard not cleared by a clear write");

   AST_TIMER_SET: assert property ( // RULE5
      acc.wr_set |=> ((timer_guard_bits & $past(timer_wmask)) == $past(timer_wmask))
   ) else $error("Timer guard not set by a set write");

   AST_TIMER_CLEAR: assert property ( // RULE5
      acc.wr_clr |=> ((timer_guard_bits & $past(timer_wmask)) == 8'h00)
   ) else $error("Timer guard not cleared by a clear write");

   AST_SERIAL_SET: assert property ( // RULE6
      acc.wr_set |=> ((serial_unit_guard_bits & $past(serial_wmask)) == $past(serial_wmask))
   ) else $error("Serial guard not set by a set write");

   AST_SERIAL_CLEAR: assert property ( // RULE6
      acc.wr_clr |=> ((serial_unit_guard_bits & $past(serial_wmask)) == 6'h00)
   ) else $error("Serial guard not cleared by a clear write");

   AST_EVENT_SET: assert property ( // RULE6
      (acc.wr_set && acc.wmask[pwg_pkg::EVENT_BIT]) |=> event_system_guard_bit
   ) else $error("Event guard not set by a set write");

   AST_EVENT_CLEAR: assert property ( // RULE6
      (acc.wr_clr && acc.wmask[pwg_pkg::EVENT_BIT]) |=> !event_system_guard_bit
   ) else $error("Event guard not cleared by a clear write");

   // State cannot move between setup and answer, so pins and data must agree
   AST_PINS_MATCH_READ: assert property ( // RULE3
      (acc.setup && acc.hit && !pwrite) |=> (prdata[pwg_pkg::TOUCH_BIT:pwg_pkg::EVENT_BIT] ==
         {touch_guard_bit, analog_out_guard_bit, comparator_guard_bit, analog_in_guard_bit,
          timer_guard_bits, serial_unit_guard_bits, event_system_guard_bit})
   ) else $error("Read data disagrees with the guard outputs");

   // One check per live bit: nothing but a written one may move it
   genvar b;
   generate
      for (b = pwg_pkg::EVENT_BIT; b <= pwg_pkg::TOUCH_BIT; b++) begin : g_keep
         AST_BIT_KEEP: assert property ( // RULE1
            !((acc.wr_clr || acc.wr_set) && acc.wmask[b]) |=> $stable(guard_ff[b])
         ) else $error("Guard bit moved without a one written to it");
      end
   endgenerate

   COV_CLEAR: cover property (acc.wr_clr ##1 (guard_ff == 32'h0000_0000));
   COV_SET: cover property (acc.wr_set ##1 (guard_ff == pwg_pkg::GUARD_MASK));
   COV_READ_BACK: cover property (acc.wr_set ##[1:2] (psel && !penable && !pwrite) ##1 pready);
   COV_REFUSED: cover property (pready && pslverr);
   COV_PARTIAL_LANES: cover property (acc.wr_clr && (pstrb != 4'hf));

endmodule

// *** testbench/test_pwg_top.sv ***
// Self-checking bench for the peripheral write guard
`timescale 1ns/1ps
module test_pwg_top;
   logic pclk;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [3:0] pstrb;
   logic pready;
   logic [31:0] prdata;
   logic pslverr;
   logic [19:1] pins;
   logic [31:0] model;
   int num_errors;
   int samples_checked;

   pwg_top dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .touch_guard_bit(pins[19]), .analog_out_guard_bit(pins[18]),
      .comparator_guard_bit(pins[17]), .analog_in_guard_bit(pins[16]),
      .timer_guard_bits(pins[15:8]), .serial_unit_guard_bits(pins[7:2]),
      .event_system_guard_bit(pins[1])
   );

   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      if (num_errors == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One APB transfer; the wait is bounded so a dead slave cannot hang the run
   task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data,
                      input logic [3:0] strb, output logic [31:0] rdata, output logic err);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= data;
      pstrb <= strb;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         num_errors++;
         stop_test();
      end
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic write_reg(input logic [11:0] addr, input logic [31:0] data, input logic [3:0] strb);
      logic [31:0] m;
      logic [31:0] rd;
      logic err;
      m = 32'h0000_0000;
      for (int i = 0; i < 4; i++) begin
         m[i*8 +: 8] = strb[i] ? data[i*8 +: 8] : 8'h00;
      end
      m = m & pwg_pkg::GUARD_MASK;
      apb(1'b1, addr, data, strb, rd, err);
      check("write slverr", 32'h0000_0000, {31'h0, err});
      if (addr[2]) begin
         model = model | m;
      end else begin
         model = model & ~m;
      end
   endtask

   // Reads both registers and the guard pins against the model
   task automatic verify();
      logic [31:0] rd;
      logic err;
      apb(1'b0, pwg_pkg::OFF_CLEAR, 32'h0000_0000, 4'h0, rd, err);
      check("clear readback", model | 32'h0080_0000, rd);
      check("clear slverr", 32'h0000_0000, {31'h0, err});
      apb(1'b0, pwg_pkg::OFF_SET, 32'h0000_0000, 4'h0, rd, err);
      check("set readback", model | 32'h0080_0000, rd);
      check("guard pins", {12'h000, model[19:1], 1'b0}, {12'h000, pins, 1'b0});
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      model = 32'h0000_0000;
      verify();
   endtask

   task automatic t_set_each();
      for (int i = 1; i < 20; i++) begin
         write_reg(pwg_pkg::OFF_SET, 32'h0000_0001 << i, 4'hf);
         verify();
      end
   endtask

   task automatic t_zero_and_clear();
      write_reg(pwg_pkg::OFF_SET, 32'h0000_0000, 4'hf);
      write_reg(pwg_pkg::OFF_CLEAR, 32'h0000_0000, 4'hf);
      verify();
      write_reg(pwg_pkg::OFF_CLEAR, 32'hffff_ffff, 4'h2);
      verify();
      write_reg(pwg_pkg::OFF_CLEAR, 32'h0000_0020, 4'hf);
      verify();
      write_reg(pwg_pkg::OFF_SET, 32'hfff0_0001, 4'hf);
      write_reg(pwg_pkg::OFF_CLEAR, 32'hff70_0001, 4'hf);
      verify();
      write_reg(pwg_pkg::OFF_CLEAR, 32'hffff_ffff, 4'hf);
      verify();
   endtask

   // Unmapped word must answer with an error and leave state alone
   task automatic t_unmapped();
      logic [31:0] rd;
      logic err;
      apb(1'b1, 12'h008, 32'hffff_ffff, 4'hf, rd, err);
      check("unmapped write slverr", 32'h0000_0001, {31'h0, err});
      apb(1'b0, 12'h008, 32'h0000_0000, 4'h0, rd, err);
      check("unmapped read slverr", 32'h0000_0001, {31'h0, err});
      check("unmapped read data", 32'h0000_0000, rd);
      verify();
   endtask

   task automatic t_mid_reset();
      write_reg(pwg_pkg::OFF_SET, 32'h000f_fffe, 4'hf);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
   endtask

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      pstrb = 4'h0;
      model = 32'h0000_0000;
      num_errors = 0;
      samples_checked = 0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_set_each();
      t_zero_and_clear();
      t_unmapped();
      t_mid_reset();
      stop_test();
   end
endmodule
